//--- inc/sxa_regs.vh
// constants for the stack and exclusive access execution block
// assumes inclusion by bare name from the monitor and core design files of the block
`ifndef SXA_REGS_VH
`define SXA_REGS_VH

// command opcodes
`define SXA_OP_W 3
`define SXA_OP_NONE 3'h0
`define SXA_OP_PUSH 3'h1
`define SXA_OP_POP 3'h2
`define SXA_OP_LDEX 3'h3
`define SXA_OP_STEX 3'h4
`define SXA_OP_CLEX 3'h5

// access sizes
`define SXA_SZ_BYTE 2'h0
`define SXA_SZ_HALF 2'h1
`define SXA_SZ_WORD 2'h2

// register numbers and stack geometry
`define SXA_IDX_PC 4'hf
`define SXA_WORD_BYTES 32'h00000004

// store exclusive status values
`define SXA_STAT_PASS 32'h00000000
`define SXA_STAT_FAIL 32'h00000001

// sequencer states
`define SXA_ST_IDLE 3'h0
`define SXA_ST_PSEL 3'h1
`define SXA_ST_PISSUE 3'h2
`define SXA_ST_PWAIT 3'h3
`define SXA_ST_LISSUE 3'h4
`define SXA_ST_LWAIT 3'h5
`define SXA_ST_XWAIT 3'h6
`define SXA_ST_FIN 3'h7

`endif

//--- verilog/sxa_scan.v
// register list scanner: lowest, highest set bit and population count
// assumes a purely combinational use by the sequencer
`timescale 1ns/1ps
`default_nettype none

module sxa_scan (
  // list in
  input wire [15:0] mask,
  // scan results
  output wire [3:0] lowest,
  output wire [3:0] highest,
  output wire [4:0] count
);

  function [3:0] low_bit;
    input [15:0] m;
    integer i;
    begin
      low_bit = 4'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        if (m[i]) begin
          low_bit = i[3:0];
        end
      end
    end
  endfunction

  function [3:0] high_bit;
    input [15:0] m;
    integer i;
    begin
      high_bit = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (m[i]) begin
          high_bit = i[3:0];
        end
      end
    end
  endfunction

  function [4:0] pop_count;
    input [15:0] m;
    integer i;
    begin
      pop_count = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        pop_count = pop_count + {4'h0, m[i]};
      end
    end
  endfunction

  assign lowest = low_bit(mask);
  assign highest = high_bit(mask);
  assign count = pop_count(mask);

endmodule // sxa_scan

`default_nettype wire

//--- verilog/sxa_monitor.v
// local exclusive monitor: address and size of the last exclusive load
// assumes snoop strobes mark accesses by other masters
`timescale 1ns/1ps
`default_nettype none
`include "sxa_regs.vh"

module sxa_monitor (
  // clock and reset
  input wire mclk,
  input wire srst,
  // arm from exclusive load
  input wire set,
  input wire [31:0] set_addr,
  input wire [1:0] set_size,
  // disarm from store exclusive or clear
  input wire clear,
  // foreign access
  input wire snoop_valid,
  input wire [31:0] snoop_addr,
  // check for store exclusive
  input wire [31:0] chk_addr,
  input wire [1:0] chk_size,
  output wire hit
);

  reg valid_q;
  reg [31:0] addr_q;
  reg [1:0] size_q;
  wire snoop_hit;

  // foreign access to the watched word kills the reservation
  assign snoop_hit = snoop_valid && (snoop_addr[31:2] == addr_q[31:2]);

  always @(posedge mclk) begin
    if (srst) begin
      valid_q <= 1'b0;
      addr_q <= 32'h00000000;
      size_q <= `SXA_SZ_WORD;
    end else if (set) begin // RULE_23
      valid_q <= 1'b1;
      addr_q <= set_addr;
      size_q <= set_size;
    end else if (clear || snoop_hit) begin // RULE_15 RULE_23
      valid_q <= 1'b0;
    end
  end

  assign hit = valid_q && (addr_q == chk_addr) && (size_q == chk_size); // RULE_23

endmodule // sxa_monitor

`default_nettype wire

//--- verilog/sxa_core.v
// stack transfer and exclusive access execution sequencer
// assumes a register file with combinational read and a req/ack memory port
//
// Summary of operation
// RULE_01: push is decrement-before, pop increment-after, on stack pointer with writeback.
// RULE_02: push puts lowest register at lowest address, highest at highest.
// RULE_03: push writes its highest address at stack pointer minus four.
// RULE_04: pop reads from stack pointer upward; pointer ends above last loaded word.
// RULE_05: after push the stack pointer holds the lowest stored address.
// RULE_06: pop with program counter branches at completion; bit 0 sets state bit.
// RULE_07: software keeps bit 0 of a popped program counter at one.
// RULE_08: lists hold no stack pointer; no program counter in push or with link.
// RULE_09: software gives a non-empty register list.
// RULE_10: conditional pop to program counter ends its conditional block.
// RULE_11: none of these operations changes the condition flags.
// RULE_12: exclusive loads read byte, halfword or word as selected.
// RULE_13: software pairs store exclusive with last exclusive load, same address, size.
// RULE_14: store exclusive status is 0 when stored, 1 when memory untouched.
// RULE_15: status 0 only if nobody else touched the location meanwhile.
// RULE_16: store exclusive to another address has no defined outcome.
// RULE_17: no program counter or stack pointer operands; status register distinct.
// RULE_18: word exclusive offsets are multiples of four in range.
// RULE_19: after clear exclusive the next store exclusive fails with status 1.
// RULE_20: software keeps exclusive pairs short.
// RULE_21: decrement-before store goes highest register first, downward.
// RULE_22: increment-after load goes lowest register first, upward.
// RULE_23: a local monitor holds address and size, cleared by store or clear.
// RULE_24: popped program counter branches with bit 0 forced to zero.
`timescale 1ns/1ps
`default_nettype none
`include "sxa_regs.vh"

module sxa_core (
  // clock and reset
  input wire mclk,
  input wire srst,
  // command port
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [1:0] cmd_size,
  input wire [15:0] cmd_reglist,
  input wire [31:0] cmd_addr,
  input wire [3:0] cmd_rt,
  input wire [3:0] cmd_rd,
  input wire [31:0] cmd_wdata,
  output reg cmd_ready,
  output reg cmd_done,
  // register file
  output reg [3:0] rf_raddr,
  input wire [31:0] rf_rdata,
  output reg rf_we,
  output reg [3:0] rf_waddr,
  output reg [31:0] rf_wdata,
  // stack pointer
  input wire [31:0] sp_value,
  output reg sp_we,
  output reg [31:0] sp_wdata,
  // branch and status
  output reg branch_valid,
  output reg [31:0] branch_target,
  output reg tbit_we,
  output reg tbit_value,
  output reg flags_we,
  // memory port
  output reg mem_req,
  output reg mem_we,
  output reg [1:0] mem_size,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  // foreign access snoop
  input wire snoop_valid,
  input wire [31:0] snoop_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [15:0] mask_q;
  reg [31:0] addr_q;
  reg [31:0] sp_final_q;
  reg [3:0] idx_q;
  reg [3:0] dst_q;
  reg [1:0] size_q;
  reg pc_hit_q;
  reg [31:0] pc_data_q;

  wire [3:0] scan_lo;
  wire [3:0] scan_hi;
  wire [3:0] cmd_lo;
  wire [3:0] cmd_hi;
  wire [4:0] cmd_cnt;
  wire mon_hit;
  wire accept;
  wire mon_set;
  wire mon_clear;
  wire [15:0] mask_left;

  function [31:0] extend;
    input [31:0] data;
    input [1:0] size;
    begin
      if (size == `SXA_SZ_BYTE) begin
        extend = {24'h000000, data[7:0]};
      end else if (size == `SXA_SZ_HALF) begin
        extend = {16'h0000, data[15:0]};
      end else begin
        extend = data;
      end
    end
  endfunction

  function [31:0] words;
    input [4:0] n;
    begin
      words = {25'h0000000, n, 2'b00};
    end
  endfunction

  assign accept = cmd_valid && cmd_ready;
  assign mask_left = mask_q & ~(16'h0001 << idx_q);

  ////////////////////////////////////////////////////////////////////////////
  // list scanners

  sxa_scan u_scan_run (
    .mask(mask_left),
    .lowest(scan_lo),
    .highest(scan_hi),
    .count()
  );

  sxa_scan u_scan_cmd (
    .mask(cmd_reglist),
    .lowest(cmd_lo),
    .highest(cmd_hi),
    .count(cmd_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // exclusive monitor

  assign mon_set = (state_q == `SXA_ST_XWAIT) && mem_ack && !mem_we;
  assign mon_clear = accept && ((cmd_op == `SXA_OP_STEX) || (cmd_op == `SXA_OP_CLEX));

  sxa_monitor u_monitor (
    .mclk(mclk),
    .srst(srst),
    .set(mon_set),
    .set_addr(addr_q),
    .set_size(size_q),
    .clear(mon_clear),
    .snoop_valid(snoop_valid),
    .snoop_addr(snoop_addr),
    .chk_addr(cmd_addr),
    .chk_size(cmd_size),
    .hit(mon_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always @(posedge mclk) begin
    if (srst) begin
      state_q <= `SXA_ST_IDLE;
      op_q <= `SXA_OP_NONE;
      mask_q <= 16'h0000;
      addr_q <= 32'h00000000;
      sp_final_q <= 32'h00000000;
      idx_q <= 4'h0;
      dst_q <= 4'h0;
      size_q <= `SXA_SZ_WORD;
      pc_hit_q <= 1'b0;
      pc_data_q <= 32'h00000000;
      cmd_ready <= 1'b1;
      cmd_done <= 1'b0;
      rf_raddr <= 4'h0;
      rf_we <= 1'b0;
      rf_waddr <= 4'h0;
      rf_wdata <= 32'h00000000;
      sp_we <= 1'b0;
      sp_wdata <= 32'h00000000;
      branch_valid <= 1'b0;
      branch_target <= 32'h00000000;
      tbit_we <= 1'b0;
      tbit_value <= 1'b0;
      flags_we <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= `SXA_SZ_WORD;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
    end else begin
      cmd_done <= 1'b0;
      rf_we <= 1'b0;
      sp_we <= 1'b0;
      branch_valid <= 1'b0;
      tbit_we <= 1'b0;
      flags_we <= 1'b0; // RULE_11
      case (state_q)
        `SXA_ST_IDLE: begin
          if (accept) begin
            op_q <= cmd_op;
            mask_q <= cmd_reglist;
            size_q <= cmd_size;
            dst_q <= cmd_rt;
            pc_hit_q <= 1'b0;
            cmd_ready <= 1'b0;
            if (cmd_op == `SXA_OP_PUSH) begin
              addr_q <= sp_value - `SXA_WORD_BYTES; // RULE_03
              sp_final_q <= sp_value - words(cmd_cnt); // RULE_01 RULE_05
              idx_q <= cmd_hi; // RULE_21
              state_q <= (cmd_reglist == 16'h0000) ? `SXA_ST_FIN : `SXA_ST_PSEL;
            end else if (cmd_op == `SXA_OP_POP) begin
              addr_q <= sp_value; // RULE_04
              sp_final_q <= sp_value + words(cmd_cnt); // RULE_01 RULE_04
              idx_q <= cmd_lo; // RULE_22
              state_q <= (cmd_reglist == 16'h0000) ? `SXA_ST_FIN : `SXA_ST_LISSUE;
            end else if (cmd_op == `SXA_OP_LDEX) begin
              addr_q <= cmd_addr;
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_size <= cmd_size; // RULE_12
              mem_addr <= cmd_addr;
              state_q <= `SXA_ST_XWAIT;
            end else if (cmd_op == `SXA_OP_STEX) begin
              addr_q <= cmd_addr;
              dst_q <= cmd_rd;
              if (mon_hit) begin // RULE_15 RULE_19 RULE_16
                mem_req <= 1'b1;
                mem_we <= 1'b1;
                mem_size <= cmd_size;
                mem_addr <= cmd_addr;
                mem_wdata <= cmd_wdata;
                state_q <= `SXA_ST_XWAIT;
              end else begin
                rf_we <= 1'b1; // RULE_14 RULE_19
                rf_waddr <= cmd_rd;
                rf_wdata <= `SXA_STAT_FAIL;
                state_q <= `SXA_ST_FIN;
              end
            end else begin
              state_q <= `SXA_ST_FIN;
            end
          end
        end
        `SXA_ST_PSEL: begin
          rf_raddr <= idx_q;
          state_q <= `SXA_ST_PISSUE;
        end
        `SXA_ST_PISSUE: begin
          mem_req <= 1'b1; // RULE_02
          mem_we <= 1'b1;
          mem_size <= `SXA_SZ_WORD;
          mem_addr <= addr_q;
          mem_wdata <= rf_rdata;
          state_q <= `SXA_ST_PWAIT;
        end
        `SXA_ST_PWAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mask_q <= mask_left;
            addr_q <= addr_q - `SXA_WORD_BYTES; // RULE_21
            idx_q <= scan_hi; // RULE_21
            state_q <= (mask_left == 16'h0000) ? `SXA_ST_FIN : `SXA_ST_PSEL;
          end
        end
        `SXA_ST_LISSUE: begin
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_size <= `SXA_SZ_WORD;
          mem_addr <= addr_q;
          state_q <= `SXA_ST_LWAIT;
        end
        `SXA_ST_LWAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (idx_q == `SXA_IDX_PC) begin
              pc_hit_q <= 1'b1; // RULE_06
              pc_data_q <= mem_rdata;
            end else begin
              rf_we <= 1'b1; // RULE_02 RULE_22
              rf_waddr <= idx_q;
              rf_wdata <= mem_rdata;
            end
            mask_q <= mask_left;
            addr_q <= addr_q + `SXA_WORD_BYTES; // RULE_22
            idx_q <= scan_lo;
            state_q <= (mask_left == 16'h0000) ? `SXA_ST_FIN : `SXA_ST_LISSUE;
          end
        end
        `SXA_ST_XWAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            rf_we <= 1'b1;
            rf_waddr <= dst_q;
            if (mem_we) begin
              rf_wdata <= `SXA_STAT_PASS; // RULE_14
            end else begin
              rf_wdata <= extend(mem_rdata, size_q); // RULE_12
            end
            state_q <= `SXA_ST_FIN;
          end
        end
        `SXA_ST_FIN: begin
          if ((op_q == `SXA_OP_PUSH) || (op_q == `SXA_OP_POP)) begin
            sp_we <= 1'b1; // RULE_01
            sp_wdata <= sp_final_q;
          end
          if (pc_hit_q) begin
            branch_valid <= 1'b1; // RULE_06
            branch_target <= {pc_data_q[31:1], 1'b0}; // RULE_24
            tbit_we <= 1'b1; // RULE_06
            tbit_value <= pc_data_q[0];
          end
          cmd_done <= 1'b1;
          cmd_ready <= 1'b1;
          state_q <= `SXA_ST_IDLE;
        end
        default: begin
          state_q <= `SXA_ST_IDLE;
        end
      endcase
    end
  end

endmodule // sxa_core

`default_nettype wire

//--- sim/sxa_mem_model.sv
// memory partner: word array with req/ack, answer delay set by lat
// assumes sub-word accesses use the low byte lane of a word
`timescale 1ns/1ps
`default_nettype none
`include "sxa_regs.vh"

module sxa_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // answer delay in cycles
  input wire logic [3:0] lat,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:63];
  logic [3:0] wait_q;
  logic [31:0] msk;

  always_comb begin
    msk = (mem_size == `SXA_SZ_BYTE) ? 32'hff :
          (mem_size == `SXA_SZ_HALF) ? 32'hffff : 32'hffffffff;
  end

  // read data only valid with ack, scrambled otherwise
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      wait_q <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_q < lat) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          mem[mem_addr[7:2]] <= (mem[mem_addr[7:2]] & ~msk) | (mem_wdata & msk);
        end else begin
          mem_rdata <= mem[mem_addr[7:2]] & msk;
        end
      end
    end
  end
endmodule // sxa_mem_model

`default_nettype wire

//--- sim/sxa_core_properties.sv
// checker for the stack and exclusive access sequencer
// assumes binding onto sxa_core, single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "sxa_regs.vh"

module sxa_core_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic [31:0] sp_value,
  // results
  input wire logic sp_we,
  input wire logic branch_valid,
  input wire logic [31:0] branch_target,
  input wire logic tbit_we,
  input wire logic flags_we,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack
);
  logic [31:0] sp_q;
  logic [31:0] last_q;
  logic [2:0] op_q;
  logic seen_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////
  // last acked address within a command
  always_ff @(posedge mclk) begin
    if (srst) begin
      seen_q <= 1'b0;
    end else if (mem_req && mem_ack) begin
      seen_q <= 1'b1;
      last_q <= mem_addr;
    end else if (cmd_done) begin
      seen_q <= 1'b0;
    end
    if (cmd_valid && cmd_ready) begin
      sp_q <= sp_value;
      op_q <= cmd_op;
    end
  end

  ////////////////////////////////////////////////////////////////
  flags_idle_a: assert property (!flags_we)
    else $error("flags written");
  branch_align_a: assert property (branch_valid |-> !branch_target[0])
    else $error("odd branch target");
  tbit_pair_a: assert property (tbit_we == branch_valid)
    else $error("state bit without branch");
  branch_end_a: assert property (branch_valid |-> cmd_done && sp_we)
    else $error("branch before completion");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped early");
  push_first_a: assert property ($rose(mem_req) && !seen_q && op_q == `SXA_OP_PUSH
    |-> mem_we && mem_addr == sp_q - 32'h4)
    else $error("push start address");
  push_step_a: assert property ($rose(mem_req) && seen_q && op_q == `SXA_OP_PUSH
    |-> mem_we && mem_addr == last_q - 32'h4)
    else $error("push step address");
  pop_first_a: assert property ($rose(mem_req) && !seen_q && op_q == `SXA_OP_POP
    |-> !mem_we && mem_addr == sp_q)
    else $error("pop start address");
  pop_step_a: assert property ($rose(mem_req) && seen_q && op_q == `SXA_OP_POP
    |-> !mem_we && mem_addr == last_q + 32'h4)
    else $error("pop step address");
  clear_fast_a: assert property (cmd_valid && cmd_ready && cmd_op == `SXA_OP_CLEX
    |-> ##2 cmd_done)
    else $error("clear not done in time");

  cover property ($rose(mem_req) && seen_q && op_q == `SXA_OP_PUSH);
  cover property (branch_valid);
  cover property (cmd_valid && cmd_ready && cmd_op == `SXA_OP_STEX);
endmodule // sxa_core_properties

bind sxa_core sxa_core_properties sxa_core_properties_inst (.mclk, .srst, .cmd_valid,
  .cmd_op, .cmd_ready, .cmd_done, .sp_value, .sp_we, .branch_valid, .branch_target,
  .tbit_we, .flags_we, .mem_req, .mem_we, .mem_addr, .mem_ack);

`default_nettype wire

//--- sim/sxa_core_tb.sv
// testbench for sxa_core with memory partner and register file stub
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
`default_nettype none
`include "sxa_regs.vh"

module sxa_core_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [1:0] cmd_size = 2'h2;
  logic [15:0] cmd_reglist = 16'h0;
  logic [31:0] cmd_addr = 32'h20;
  logic [3:0] cmd_rt = 4'h2;
  logic [3:0] cmd_rd = 4'h5;
  logic [31:0] cmd_wdata = 32'h11223344;
  logic [31:0] sp_value = 32'h0;
  logic snoop_valid = 1'b0;
  logic [31:0] snoop_addr = 32'h22;
  logic [3:0] lat = 4'h0;
  logic [3:0] rf_a;
  logic [31:0] rf_d, sp_d, br_d;
  logic tbit_d;
  int fails = 0;
  int cmp_count = 0;
  wire cmd_ready, cmd_done, rf_we, sp_we, branch_valid, tbit_we, tbit_value, flags_we;
  wire mem_req, mem_we, mem_ack;
  wire [3:0] rf_raddr, rf_waddr;
  wire [1:0] mem_size;
  wire [31:0] rf_wdata, sp_wdata, branch_target, mem_addr, mem_wdata, mem_rdata;
  wire [31:0] rf_rdata = {28'h1234567, rf_raddr};

  always #2.5 mclk = ~mclk;

  sxa_core sxa_core_inst (.mclk, .srst, .cmd_valid, .cmd_op, .cmd_size, .cmd_reglist,
    .cmd_addr, .cmd_rt, .cmd_rd, .cmd_wdata, .cmd_ready, .cmd_done, .rf_raddr, .rf_rdata,
    .rf_we, .rf_waddr, .rf_wdata, .sp_value, .sp_we, .sp_wdata, .branch_valid,
    .branch_target, .tbit_we, .tbit_value, .flags_we, .mem_req, .mem_we, .mem_size,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .snoop_valid, .snoop_addr);

  sxa_mem_model sxa_mem_model_inst (.mclk, .srst, .lat, .mem_req, .mem_we, .mem_size,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  ////////////////////////////////////////////////////////////////
  // result recorder
  always @(posedge mclk) begin
    if (cmd_valid && cmd_ready) begin
      rf_d <= 32'h5a5a5a5a;
      sp_d <= 32'h5a5a5a5a;
      br_d <= 32'h5a5a5a5a;
    end
    if (rf_we) begin
      rf_a <= rf_waddr;
      rf_d <= rf_wdata;
    end
    if (sp_we) begin
      sp_d <= sp_wdata;
    end
    if (branch_valid) begin
      br_d <= branch_target;
      tbit_d <= tbit_value;
    end
  end

  function automatic logic [31:0] rfv(input logic [3:0] r);
    return {28'h1234567, r};
  endfunction

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // offer one command, wait for take and done
  task automatic issue(input logic [2:0] op, input logic [1:0] sz, input logic [15:0] rl,
                       input logic [31:0] sp, input logic [3:0] l);
    int i;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_size <= sz;
    cmd_reglist <= rl;
    sp_value <= sp;
    lat <= l;
    for (i = 0; i < 50 && !(cmd_valid && cmd_ready); i++) @(posedge mclk);
    if (i == 50) begin
      fails++;
      $display("unexpected at %0t: not taken", $time);
      wrap_up();
    end
    cmd_valid <= 1'b0;
    for (i = 0; i < 50 && cmd_done !== 1'b1; i++) @(posedge mclk);
    if (i == 50) begin
      fails++;
      $display("unexpected at %0t: no done", $time);
      wrap_up();
    end
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_push();
    issue(`SXA_OP_PUSH, `SXA_SZ_WORD, 16'h400a, 32'h40, 4'h0);
    chk(sxa_mem_model_inst.mem[15], rfv(4'he));
    chk(sxa_mem_model_inst.mem[14], rfv(4'h3));
    chk(sxa_mem_model_inst.mem[13], rfv(4'h1));
    chk(sp_d, 32'h34);
  endtask

  task automatic t_pop();
    sxa_mem_model_inst.mem[13] = 32'h0000c0de;
    sxa_mem_model_inst.mem[14] = 32'h00000101;
    issue(`SXA_OP_POP, `SXA_SZ_WORD, 16'h8001, 32'h34, 4'h3);
    chk({28'h0, rf_a}, 32'h0);
    chk(rf_d, 32'h0000c0de);
    chk(sp_d, 32'h3c);
    chk(br_d, 32'h100);
    chk({31'h0, tbit_d}, 32'h1);
  endtask

  task automatic t_excl();
    int s;
    logic [31:0] m;
    for (s = 0; s < 3; s++) begin
      m = (s == 0) ? 32'hff : (s == 1) ? 32'hffff : 32'hffffffff;
      sxa_mem_model_inst.mem[8] = 32'h8899aabb;
      issue(`SXA_OP_LDEX, s[1:0], 16'h0, 32'h0, 4'h1);
      chk({28'h0, rf_a}, 32'h2);
      chk(rf_d, 32'h8899aabb & m);
      issue(`SXA_OP_STEX, s[1:0], 16'h0, 32'h0, 4'h2);
      chk({28'h0, rf_a}, 32'h5);
      chk(rf_d, `SXA_STAT_PASS);
      chk(sxa_mem_model_inst.mem[8], (32'h8899aabb & ~m) | (32'h11223344 & m));
    end
    sxa_mem_model_inst.mem[8] = 32'h0;
    issue(`SXA_OP_STEX, `SXA_SZ_WORD, 16'h0, 32'h0, 4'h0);
    chk(rf_d, `SXA_STAT_FAIL);
    chk(sxa_mem_model_inst.mem[8], 32'h0);
  endtask

  task automatic t_clear();
    issue(`SXA_OP_LDEX, `SXA_SZ_WORD, 16'h0, 32'h0, 4'h0);
    issue(`SXA_OP_CLEX, `SXA_SZ_WORD, 16'h0, 32'h0, 4'h0);
    issue(`SXA_OP_STEX, `SXA_SZ_WORD, 16'h0, 32'h0, 4'h0);
    chk(rf_d, `SXA_STAT_FAIL);
    chk(sxa_mem_model_inst.mem[8], 32'h0);
  endtask

  task automatic t_snoop();
    issue(`SXA_OP_LDEX, `SXA_SZ_WORD, 16'h0, 32'h0, 4'h0);
    @(posedge mclk);
    snoop_valid <= 1'b1;
    @(posedge mclk);
    snoop_valid <= 1'b0;
    issue(`SXA_OP_STEX, `SXA_SZ_WORD, 16'h0, 32'h0, 4'h0);
    chk(rf_d, `SXA_STAT_FAIL);
    chk(sxa_mem_model_inst.mem[8], 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_push();
    t_pop();
    t_excl();
    t_clear();
    t_snoop();
    wrap_up();
  end
endmodule // sxa_core_tb

`default_nettype wire
